// [inc/cfdbd_regs.svh]
// Register map, field positions and reset values of the CAN FD bus
// diagnostics and filter routing block; included by the package, whose macros the rtl uses.
`ifndef CFDBD_REGS_SVH
`define CFDBD_REGS_SVH
`define CFDBD_ADR_W 5
`define CFDBD_OFF_DCNT 5'h00
`define CFDBD_OFF_NCNT 5'h04
`define CFDBD_OFF_FLAG 5'h08
`define CFDBD_OFF_GOOD 5'h0c
`define CFDBD_OFF_FLT0 5'h10
`define CFDBD_FLT_GROUPS 4
`define CFDBD_RST16 16'h0000
`define CFDBD_FLAG_MASK 16'hfbbf
`define CFDBD_FLT_MASK 16'h9f9f
`define CFDBD_B_LENGTH_MISMATCH_FLAG 15
`define CFDBD_B_ESI 14
`define CFDBD_B_DCRC 13
`define CFDBD_B_DSTUF 12
`define CFDBD_B_DFORM 11
`define CFDBD_B_DBIT1 9
`define CFDBD_B_DBIT0 8
`define CFDBD_B_BOFF 7
`define CFDBD_B_NCRC 5
`define CFDBD_B_NSTUF 4
`define CFDBD_B_NFORM 3
`define CFDBD_B_NACK 2
`define CFDBD_B_NBIT1 1
`define CFDBD_B_NBIT0 0
`define CFDBD_EN_BIT 7
`define CFDBD_PTR_W 5
`define CFDBD_OBJ_MIN 5'h01
`define CFDBD_OBJ_MAX 5'h07
`define CFDBD_STUFF_RUN 3'h5
`define CFDBD_RECOV_LAST 4'ha
`define CFDBD_CRC_W 21
`endif

// [inc/cfdbd_pkg.sv]
// Types shared by the diagnostics block.
// Assumes cfdbd_regs.svh sits on the include path.
package cfdbd_pkg;
  `include "cfdbd_regs.svh"
  typedef enum {
    CFDBD_SEL_DCNT,
    CFDBD_SEL_NCNT,
    CFDBD_SEL_FLAG,
    CFDBD_SEL_GOOD,
    CFDBD_SEL_FLT,
    CFDBD_SEL_NONE
  } cfdbd_sel_t;
endpackage : cfdbd_pkg

// [rtl/cfdbd_top.sv]
// CAN FD bus diagnostics counters, sticky error flags and filter c/d routing.
// Assumes a protocol engine on clk_i giving one-cycle event and bit pulses.
// Functional notes
// RQ1: Count data-phase transmit errors, eight bits, upper byte of data counts.
// RQ2: Count data-phase receive errors, eight bits, lower byte of data counts.
// RQ3: Count nominal-phase transmit errors, eight bits, upper byte of nominal counts.
// RQ4: Count nominal-phase receive errors, eight bits, lower byte of nominal counts.
// RQ5: Flag length mismatch when frame length exceeds element payload size.
// RQ6: Flag received FD frame whose ESI bit is set.
// RQ7: Data-phase CRC, stuff, form, bit flags set only in data phase.
// RQ8: Flag bus-off entered and automatically recovered.
// RQ9: Flag nominal CRC error when computed and received checksums differ.
// RQ10: Flag stuffing error on more than five equal stuffed bits.
// RQ11: Flag form error on illegal fixed-format field.
// RQ12: Flag acknowledge error when own frame gets no acknowledge.
// RQ13: Flag recessive sent, dominant seen, outside arbitration; the code also skips the ack slot.
// RQ14: Flag dominant sent, recessive seen, including ack and error flags.
// RQ15: In bus-off recovery set dominant-bit flag per eleven recessive bits.
// RQ16: Sixteen-bit error-free message counter, software read and write.
// RQ17: Filters d and c accept only when their enable bits are one.
// RQ18: Enabled hit stores to object named by pointer, one to seven.
// RQ19: Software never programs pointer codes one thousand to all ones.
// RQ20: Software never points a filter at object zero.
// RQ21: Unimplemented bits read as zero.
// RQ22: Flags stay set until software writes zero; events win over clears.
// RQ23: Reset clears counters, flags and filter fields to zero.
`timescale 1ns/10ps
module cfdbd_top
  import cfdbd_pkg::*;
#(
  parameter int CNT_W = 8,
  parameter int GOOD_W = 16,
  parameter int GROUPS = `CFDBD_FLT_GROUPS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [`CFDBD_ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic data_phase_i,
  input wire logic tx_err_i,
  input wire logic rx_err_i,
  input wire logic msg_ok_i,
  input wire logic dlc_check_i,
  input wire logic [3:0] frame_dlc_i,
  input wire logic [2:0] fifo_payload_size_i,
  input wire logic rx_done_i,
  input wire logic rx_fd_i,
  input wire logic rx_esi_i,
  input wire logic crc_check_i,
  input wire logic [`CFDBD_CRC_W-1:0] crc_calc_i,
  input wire logic [`CFDBD_CRC_W-1:0] crc_rx_i,
  input wire logic form_err_i,
  input wire logic bit_valid_i,
  input wire logic bit_rx_i,
  input wire logic bit_tx_i,
  input wire logic tx_active_i,
  input wire logic arbitration_i,
  input wire logic ack_slot_i,
  input wire logic stuff_zone_i,
  input wire logic bus_off_i,
  input wire logic filt_eval_i,
  input wire logic [2*GROUPS-1:0] filt_hit_i,
  output logic route_valid_o,
  output logic [`CFDBD_PTR_W-1:0] route_obj_o
);

  function automatic cfdbd_sel_t reg_sel(input logic [`CFDBD_ADR_W-1:0] a);
    cfdbd_sel_t s;
    s = CFDBD_SEL_NONE;
    case (a)
      `CFDBD_OFF_DCNT: s = CFDBD_SEL_DCNT;
      `CFDBD_OFF_NCNT: s = CFDBD_SEL_NCNT;
      `CFDBD_OFF_FLAG: s = CFDBD_SEL_FLAG;
      `CFDBD_OFF_GOOD: s = CFDBD_SEL_GOOD;
      default: begin
        if (a >= `CFDBD_OFF_FLT0 && a[1:0] == 2'h0) begin
          s = CFDBD_SEL_FLT;
        end
      end
    endcase
    return s;
  endfunction : reg_sel

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    return (&v) ? v : v + 1'b1;
  endfunction : sat_inc

  function automatic logic [6:0] dlc_bytes(input logic [3:0] d);
    logic [6:0] n;
    n = 7'h08;
    case (d)
      4'h9: n = 7'h0c;
      4'ha: n = 7'h10;
      4'hb: n = 7'h14;
      4'hc: n = 7'h18;
      4'hd: n = 7'h20;
      4'he: n = 7'h30;
      4'hf: n = 7'h40;
      default: n = (d > 4'h8) ? 7'h08 : {3'h0, d};
    endcase
    return n;
  endfunction : dlc_bytes

  function automatic logic [6:0] pl_bytes(input logic [2:0] p);
    logic [6:0] n;
    n = 7'h08;
    case (p)
      3'h0: n = 7'h08;
      3'h1: n = 7'h0c;
      3'h2: n = 7'h10;
      3'h3: n = 7'h14;
      3'h4: n = 7'h18;
      3'h5: n = 7'h20;
      3'h6: n = 7'h30;
      default: n = 7'h40;
    endcase
    return n;
  endfunction : pl_bytes

  logic [CNT_W-1:0] dtx_r, drx_r, ntx_r, nrx_r;
  logic [GOOD_W-1:0] good_r;
  logic [15:0] flags_r;
  logic [15:0] set_vec;
  logic [15:0] flt_r [GROUPS];
  logic [2:0] run_r;
  logic last_bit_r;
  logic [3:0] rec_r;
  logic bus_off_d_r;
  logic bus_req, wr_en;
  cfdbd_sel_t sel;
  logic [1:0] grp;
  logic [15:0] wmask;
  logic stuff_err, rec_fire, bit0_err, bit1_err, ack_err;

  // Bus slave: one wait state, ack drops after one cycle
  assign bus_req = cyc_i && stb_i && !ack_o;
  assign wr_en = bus_req && we_i;
  assign sel = reg_sel(adr_i);
  assign grp = adr_i[3:2];
  assign wmask = {{8{sel_i[1]}}, {8{sel_i[0]}}};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (bus_req && !we_i) begin
      case (sel)
        CFDBD_SEL_DCNT: dat_o <= {16'h0000, dtx_r, drx_r};
        CFDBD_SEL_NCNT: dat_o <= {16'h0000, ntx_r, nrx_r};
        CFDBD_SEL_FLAG: dat_o <= {16'h0000, flags_r & `CFDBD_FLAG_MASK}; // RQ21
        CFDBD_SEL_GOOD: dat_o <= {16'h0000, good_r};
        CFDBD_SEL_FLT: dat_o <= {16'h0000, flt_r[grp] & `CFDBD_FLT_MASK}; // RQ21
        default: dat_o <= 32'h0000_0000;
      endcase
    end
  end

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] wd,
                                        input logic [15:0] m);
    return (old & ~m) | (wd & m);
  endfunction : merge

  // Error counters; a write loads, a same-cycle event still counts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dtx_r <= '0; // RQ23
      drx_r <= '0;
    end else begin
      logic [15:0] v;
      v = {dtx_r, drx_r};
      if (wr_en && sel == CFDBD_SEL_DCNT) begin
        v = merge(v, dat_i[15:0], wmask);
      end
      dtx_r <= (tx_err_i && data_phase_i) ? sat_inc(v[15:8]) : v[15:8]; // RQ1
      drx_r <= (rx_err_i && data_phase_i) ? sat_inc(v[7:0]) : v[7:0]; // RQ2
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ntx_r <= '0;
      nrx_r <= '0;
    end else begin
      logic [15:0] v;
      v = {ntx_r, nrx_r};
      if (wr_en && sel == CFDBD_SEL_NCNT) begin
        v = merge(v, dat_i[15:0], wmask);
      end
      ntx_r <= (tx_err_i && !data_phase_i) ? sat_inc(v[15:8]) : v[15:8]; // RQ3
      nrx_r <= (rx_err_i && !data_phase_i) ? sat_inc(v[7:0]) : v[7:0]; // RQ4
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      good_r <= '0;
    end else begin
      logic [15:0] v;
      v = good_r;
      if (wr_en && sel == CFDBD_SEL_GOOD) begin
        v = merge(v, dat_i[15:0], wmask);
      end
      good_r <= msg_ok_i ? ((&v) ? v : v + 16'h0001) : v; // RQ16
    end
  end

  // Run of equal bits inside stuffed fields
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_r <= 3'h0;
      last_bit_r <= 1'b1;
    end else if (bit_valid_i) begin
      last_bit_r <= bit_rx_i;
      if (!stuff_zone_i || bit_rx_i != last_bit_r || run_r == 3'h0) begin
        run_r <= stuff_zone_i ? 3'h1 : 3'h0;
      end else if (run_r != `CFDBD_STUFF_RUN) begin
        run_r <= run_r + 3'h1;
      end
    end
  end
  assign stuff_err = bit_valid_i && stuff_zone_i && bit_rx_i == last_bit_r &&
                     run_r == `CFDBD_STUFF_RUN; // RQ10

  // Recessive bit runs while bus-off recovery is under way
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rec_r <= 4'h0;
    end else if (!bus_off_i) begin
      rec_r <= 4'h0;
    end else if (bit_valid_i) begin
      if (!bit_rx_i || rec_r == `CFDBD_RECOV_LAST) begin
        rec_r <= 4'h0;
      end else begin
        rec_r <= rec_r + 4'h1;
      end
    end
  end
  assign rec_fire = bus_off_i && bit_valid_i && bit_rx_i &&
                    rec_r == `CFDBD_RECOV_LAST; // RQ15

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_off_d_r <= 1'b0;
    end else begin
      bus_off_d_r <= bus_off_i;
    end
  end

  // Own bit versus bus level; bit_rx_i high means recessive
  assign bit0_err = bit_valid_i && tx_active_i && !bit_tx_i && bit_rx_i; // RQ14
  assign bit1_err = bit_valid_i && tx_active_i && bit_tx_i && !bit_rx_i &&
                    !arbitration_i && !ack_slot_i; // RQ13
  assign ack_err = bit_valid_i && tx_active_i && ack_slot_i && bit_tx_i &&
                   bit_rx_i; // RQ12

  always_comb begin
    set_vec = 16'h0000;
    set_vec[`CFDBD_B_LENGTH_MISMATCH_FLAG] = dlc_check_i &&
      dlc_bytes(frame_dlc_i) > pl_bytes(fifo_payload_size_i); // RQ5
    set_vec[`CFDBD_B_ESI] = rx_done_i && rx_fd_i && rx_esi_i; // RQ6
    set_vec[`CFDBD_B_DCRC] = data_phase_i && crc_check_i &&
      crc_calc_i != crc_rx_i; // RQ7
    set_vec[`CFDBD_B_DSTUF] = data_phase_i && stuff_err;
    set_vec[`CFDBD_B_DFORM] = data_phase_i && form_err_i;
    set_vec[`CFDBD_B_DBIT1] = data_phase_i && bit1_err;
    set_vec[`CFDBD_B_DBIT0] = data_phase_i && bit0_err;
    set_vec[`CFDBD_B_BOFF] = bus_off_d_r && !bus_off_i; // RQ8
    set_vec[`CFDBD_B_NCRC] = !data_phase_i && crc_check_i &&
      crc_calc_i != crc_rx_i; // RQ9
    set_vec[`CFDBD_B_NSTUF] = !data_phase_i && stuff_err; // RQ10
    set_vec[`CFDBD_B_NFORM] = !data_phase_i && form_err_i; // RQ11
    set_vec[`CFDBD_B_NACK] = ack_err; // RQ12
    set_vec[`CFDBD_B_NBIT1] = !data_phase_i && bit1_err; // RQ13
    set_vec[`CFDBD_B_NBIT0] = (!data_phase_i && bit0_err) || rec_fire; // RQ14 RQ15
  end

  // Sticky flags: writes may clear, a same-cycle event wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_r <= `CFDBD_RST16; // RQ23
    end else begin
      logic [15:0] v;
      v = flags_r;
      if (wr_en && sel == CFDBD_SEL_FLAG) begin
        v = merge(v, dat_i[15:0], wmask);
      end
      flags_r <= (v | set_vec) & `CFDBD_FLAG_MASK; // RQ22 RQ21
    end
  end

  // Filter control words, one per group: d in high byte, c in low byte
  genvar g;
  generate
    for (g = 0; g < GROUPS; g++) begin : g_flt
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          flt_r[g] <= `CFDBD_RST16; // RQ23
        end else if (wr_en && sel == CFDBD_SEL_FLT && grp == 2'(g)) begin
          flt_r[g] <= merge(flt_r[g], dat_i[15:0], wmask) & `CFDBD_FLT_MASK;
        end
      end
    end
  endgenerate

  // Lowest enabled hit with a usable pointer decides the object
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      route_valid_o <= 1'b0;
      route_obj_o <= '0;
    end else begin
      logic found;
      logic [7:0] half;
      logic [`CFDBD_PTR_W-1:0] p;
      found = 1'b0;
      half = 8'h00;
      p = '0;
      route_valid_o <= 1'b0;
      if (filt_eval_i) begin
        for (int i = 0; i < 2 * GROUPS; i++) begin
          half = i[0] ? flt_r[i / 2][15:8] : flt_r[i / 2][7:0];
          p = half[`CFDBD_PTR_W-1:0];
          if (!found && filt_hit_i[i] && half[`CFDBD_EN_BIT] && // RQ17
              p >= `CFDBD_OBJ_MIN && p <= `CFDBD_OBJ_MAX) begin // RQ18 RQ19 RQ20
            found = 1'b1;
            route_valid_o <= 1'b1;
            route_obj_o <= p;
          end
        end
      end
    end
  end

  // Checks
  wire flag_wr = wr_en && sel == CFDBD_SEL_FLAG;
  sequence s_rec_bit;
    bus_off_i && bit_valid_i && bit_rx_i;
  endsequence
  sequence s_rec_full;
    s_rec_bit ##0 rec_r == `CFDBD_RECOV_LAST;
  endsequence

  dtx_count_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ1
    tx_err_i && data_phase_i && !wr_en && dtx_r != 8'hff |=> dtx_r == $past(dtx_r) + 8'h01)
    else $error("data tx count missed");
  drx_count_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ2
    rx_err_i && data_phase_i && !wr_en && drx_r != 8'hff |=> drx_r == $past(drx_r) + 8'h01)
    else $error("data rx count missed");
  ntx_count_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ3
    tx_err_i && !data_phase_i && !wr_en && ntx_r != 8'hff |=> ntx_r == $past(ntx_r) + 8'h01 &&
      dtx_r == $past(dtx_r))
    else $error("nominal tx count missed or counted as data");
  nrx_count_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ4
    rx_err_i && !data_phase_i && !wr_en && nrx_r != 8'hff |=> nrx_r == $past(nrx_r) + 8'h01)
    else $error("nominal rx count missed");
  esi_flag_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ6
    rx_done_i && rx_fd_i && rx_esi_i |=> flags_r[`CFDBD_B_ESI])
    else $error("esi flag not set");
  busoff_event_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ8
    bus_off_i ##1 !bus_off_i |=> flags_r[`CFDBD_B_BOFF])
    else $error("bus-off event flag not set");
  recov_flag_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ15
    s_rec_full |=> flags_r[`CFDBD_B_NBIT0] && rec_r == 4'h0)
    else $error("recovery run not flagged");
  flag_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ22
    !flag_wr |=> (flags_r & $past(flags_r)) == $past(flags_r))
    else $error("flag lost without write");
  unimpl_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ21
    ack_o && !we_i && $past(sel) == CFDBD_SEL_FLAG |-> dat_o[10] == 1'b0 && dat_o[6] == 1'b0)
    else $error("unimplemented flag bit reads one");
  route_ptr_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ18
    route_valid_o |-> route_obj_o >= 5'h01 && route_obj_o <= 5'h07)
    else $error("route to illegal object");
  route_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ17
    filt_eval_i && filt_hit_i == 8'h01 && !flt_r[0][7] |=> !route_valid_o)
    else $error("disabled filter routed");
  reset_clear_a: assert property (@(posedge clk_i) // RQ23
    rst_i |=> flags_r == 16'h0000 && good_r == 16'h0000 && dtx_r == 8'h00)
    else $error("reset left state");
endmodule : cfdbd_top

// [sim/cfdbd_bus_model.sv]
// Far-side CAN bus model: frame events, levels and a sampled bit stream.
// Assumes the bench calls its tasks; outputs change just after clk_i edges.
`timescale 1ns/10ps
module cfdbd_bus_model (
  input wire logic clk_i,
  output logic data_phase_o,
  output logic tx_err_o,
  output logic rx_err_o,
  output logic msg_ok_o,
  output logic dlc_check_o,
  output logic [3:0] frame_dlc_o,
  output logic [2:0] payload_size_o,
  output logic rx_done_o,
  output logic rx_fd_o,
  output logic rx_esi_o,
  output logic crc_check_o,
  output logic [20:0] crc_calc_o,
  output logic [20:0] crc_rx_o,
  output logic form_err_o,
  output logic bit_valid_o,
  output logic bit_rx_o,
  output logic bit_tx_o,
  output logic tx_active_o,
  output logic arbitration_o,
  output logic ack_slot_o,
  output logic stuff_zone_o,
  output logic bus_off_o
);
  initial begin
    {data_phase_o, tx_err_o, rx_err_o, msg_ok_o, dlc_check_o, frame_dlc_o, payload_size_o,
     rx_done_o, rx_fd_o, rx_esi_o, crc_check_o, crc_calc_o, crc_rx_o, form_err_o,
     bit_valid_o, tx_active_o, arbitration_o, ack_slot_o, stuff_zone_o, bus_off_o} = '0;
    {bit_rx_o, bit_tx_o} = 2'b11;
  end

  task automatic lvl(input logic [5:0] v);
    @(posedge clk_i);
    {data_phase_o, tx_active_o, arbitration_o, ack_slot_o, stuff_zone_o, bus_off_o} <= v;
  endtask : lvl

  task automatic fld(input logic [3:0] d, input logic [2:0] p, input logic fd,
                     input logic e, input logic [20:0] cc, input logic [20:0] c);
    @(posedge clk_i);
    {frame_dlc_o, payload_size_o, rx_fd_o, rx_esi_o, crc_calc_o, crc_rx_o} <=
      {d, p, fd, e, cc, c};
  endtask : fld

  // One bit each, msb first: tx, rx, ok, dlc, done, crc, form
  task automatic pulse(input logic [6:0] k);
    @(posedge clk_i);
    {tx_err_o, rx_err_o, msg_ok_o, dlc_check_o, rx_done_o, crc_check_o, form_err_o} <= k;
    @(posedge clk_i);
    {tx_err_o, rx_err_o, msg_ok_o, dlc_check_o, rx_done_o, crc_check_o, form_err_o} <= 7'h00;
  endtask : pulse

  // Released bus floats recessive
  task automatic bits(input int n, input logic t, input logic r);
    repeat (n) begin
      @(posedge clk_i);
      {bit_valid_o, bit_tx_o, bit_rx_o} <= {1'b1, t, r};
    end
    @(posedge clk_i);
    {bit_valid_o, bit_tx_o, bit_rx_o} <= 3'b011;
  endtask : bits
endmodule : cfdbd_bus_model

// [sim/testbench.sv]
// Self-checking bench for the bus diagnostics and filter routing block.
// Assumes cfdbd_pkg and the bus model are compiled before this file.
`timescale 1ns/10ps
module testbench;
  import cfdbd_pkg::*;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, filt_eval_i, route_valid_o;
  logic [4:0] adr_i, route_obj_o;
  logic [3:0] sel_i, frame_dlc_i;
  logic [31:0] dat_i, dat_o;
  logic [7:0] filt_hit_i;
  logic [2:0] psz;
  logic [20:0] crc_calc_i, crc_rx_i;
  logic data_phase_i, tx_err_i, rx_err_i, msg_ok_i, dlc_check_i, rx_done_i, rx_fd_i;
  logic rx_esi_i, crc_check_i, form_err_i, bit_valid_i, bit_rx_i, bit_tx_i, tx_active_i;
  logic arbitration_i, ack_slot_i, stuff_zone_i, bus_off_i;
  int mismatches;
  int tests_run;

  cfdbd_top u_cfdbd_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .data_phase_i(data_phase_i), .tx_err_i(tx_err_i), .rx_err_i(rx_err_i),
    .msg_ok_i(msg_ok_i), .dlc_check_i(dlc_check_i), .frame_dlc_i(frame_dlc_i),
    .fifo_payload_size_i(psz), .rx_done_i(rx_done_i), .rx_fd_i(rx_fd_i),
    .rx_esi_i(rx_esi_i), .crc_check_i(crc_check_i), .crc_calc_i(crc_calc_i),
    .crc_rx_i(crc_rx_i), .form_err_i(form_err_i), .bit_valid_i(bit_valid_i),
    .bit_rx_i(bit_rx_i), .bit_tx_i(bit_tx_i), .tx_active_i(tx_active_i),
    .arbitration_i(arbitration_i), .ack_slot_i(ack_slot_i), .stuff_zone_i(stuff_zone_i),
    .bus_off_i(bus_off_i), .filt_eval_i(filt_eval_i), .filt_hit_i(filt_hit_i),
    .route_valid_o(route_valid_o), .route_obj_o(route_obj_o));

  cfdbd_bus_model u_cfdbd_bus_model (.clk_i(clk_i), .data_phase_o(data_phase_i),
    .tx_err_o(tx_err_i), .rx_err_o(rx_err_i), .msg_ok_o(msg_ok_i),
    .dlc_check_o(dlc_check_i), .frame_dlc_o(frame_dlc_i), .payload_size_o(psz),
    .rx_done_o(rx_done_i), .rx_fd_o(rx_fd_i), .rx_esi_o(rx_esi_i),
    .crc_check_o(crc_check_i), .crc_calc_o(crc_calc_i), .crc_rx_o(crc_rx_i),
    .form_err_o(form_err_i), .bit_valid_o(bit_valid_i), .bit_rx_o(bit_rx_i),
    .bit_tx_o(bit_tx_i), .tx_active_o(tx_active_i), .arbitration_o(arbitration_i),
    .ack_slot_o(ack_slot_i), .stuff_zone_o(stuff_zone_i), .bus_off_o(bus_off_i));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [4:0] a, input logic [15:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, 4'hf, 16'h0000, d};
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    {cyc_i, stb_i} <= 2'b00;
    // Ack is a single-cycle pulse
    @(posedge clk_i);
    chk("ack drop", 32'h0, {31'h0, ack_o});
  endtask : wb

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    logic [31:0] q;
    wb(1'b0, a, 16'h0000, q);
    chk($sformatf("reg %h", a), {16'h0000, e}, q);
  endtask : rd

  // Read flag word, then clear it
  task automatic flg(input logic [15:0] e);
    rd(5'h08, e);
    wr(5'h08, 16'h0000);
  endtask : flg

  task automatic route(input logic [7:0] h, input logic v, input logic [4:0] o);
    @(posedge clk_i);
    {filt_eval_i, filt_hit_i} <= {1'b1, h};
    @(posedge clk_i);
    {filt_eval_i, filt_hit_i} <= 9'h000;
    #1;
    chk("route valid", {31'h0, v}, {31'h0, route_valid_o});
    if (v) chk("route obj", {27'h0, o}, {27'h0, route_obj_o});
  endtask : route

  task automatic t_reset();
    for (int a = 0; a < 8; a++) rd(5'(a * 4), 16'h0000);
    $display("reset values done");
  endtask : t_reset

  task automatic t_counts();
    u_cfdbd_bus_model.lvl(6'h20);
    repeat (4) u_cfdbd_bus_model.pulse(7'h40);
    u_cfdbd_bus_model.pulse(7'h20);
    u_cfdbd_bus_model.lvl(6'h00);
    repeat (2) u_cfdbd_bus_model.pulse(7'h40);
    repeat (3) u_cfdbd_bus_model.pulse(7'h20);
    rd(5'h00, 16'h0401);
    rd(5'h04, 16'h0203);
    wr(5'h04, 16'h10fe);
    repeat (2) u_cfdbd_bus_model.pulse(7'h20);
    rd(5'h04, 16'h10ff);
    wr(5'h0c, 16'h1234);
    repeat (3) u_cfdbd_bus_model.pulse(7'h10);
    rd(5'h0c, 16'h1237);
    wr(5'h02, 16'hffff);
    rd(5'h02, 16'h0000);
    $display("counters done");
  endtask : t_counts

  task automatic t_flags();
    u_cfdbd_bus_model.fld(4'h8, 3'h0, 1'b1, 1'b0, 21'h1c3e07, 21'h1c3e07);
    u_cfdbd_bus_model.pulse(7'h0e);
    flg(16'h0000);
    u_cfdbd_bus_model.fld(4'h9, 3'h0, 1'b1, 1'b1, 21'h1c3e07, 21'h1c3e06);
    u_cfdbd_bus_model.pulse(7'h0e);
    flg(16'hc020);
    u_cfdbd_bus_model.lvl(6'h20);
    u_cfdbd_bus_model.pulse(7'h03);
    flg(16'h2800);
    u_cfdbd_bus_model.lvl(6'h00);
    u_cfdbd_bus_model.pulse(7'h01);
    flg(16'h0008);
    u_cfdbd_bus_model.lvl(6'h02);
    u_cfdbd_bus_model.bits(5, 1'b1, 1'b0);
    u_cfdbd_bus_model.bits(1, 1'b1, 1'b1);
    flg(16'h0000);
    u_cfdbd_bus_model.bits(6, 1'b1, 1'b0);
    flg(16'h0010);
    u_cfdbd_bus_model.lvl(6'h22);
    u_cfdbd_bus_model.bits(6, 1'b1, 1'b0);
    flg(16'h1000);
    u_cfdbd_bus_model.lvl(6'h18);
    u_cfdbd_bus_model.bits(1, 1'b1, 1'b0);
    flg(16'h0000);
    for (int p = 0; p < 2; p++) begin
      u_cfdbd_bus_model.lvl(p ? 6'h30 : 6'h10);
      u_cfdbd_bus_model.bits(1, 1'b1, 1'b0);
      u_cfdbd_bus_model.bits(1, 1'b0, 1'b1);
      flg(p ? 16'h0300 : 16'h0003);
    end
    u_cfdbd_bus_model.lvl(6'h14);
    u_cfdbd_bus_model.bits(1, 1'b1, 1'b1);
    flg(16'h0004);
    u_cfdbd_bus_model.lvl(6'h01);
    u_cfdbd_bus_model.bits(10, 1'b1, 1'b1);
    flg(16'h0000);
    u_cfdbd_bus_model.bits(11, 1'b1, 1'b1);
    flg(16'h0001);
    u_cfdbd_bus_model.lvl(6'h00);
    flg(16'h0080);
    wr(5'h08, 16'hffff);
    flg(16'hfbbf);
    rd(5'h08, 16'h0000);
    $display("flags done");
  endtask : t_flags

  task automatic t_filter();
    wr(5'h10, 16'h8703);
    wr(5'h18, 16'h0081);
    wr(5'h1c, 16'he7e7);
    rd(5'h10, 16'h8703);
    rd(5'h1c, 16'h8787);
    route(8'h01, 1'b0, 5'h00);
    route(8'h02, 1'b1, 5'h07);
    route(8'h10, 1'b1, 5'h01);
    route(8'h20, 1'b0, 5'h00);
    route(8'h40, 1'b1, 5'h07);
    $display("filter routing done");
  endtask : t_filter

  task automatic t_rerun();
    wr(5'h08, 16'h0024);
    wr(5'h0c, 16'h00aa);
    rd(5'h08, 16'h0024);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(5'h08, 16'h0000);
    rd(5'h0c, 16'h0000);
    rd(5'h1c, 16'h0000);
    rd(5'h00, 16'h0000);
    $display("mid-run reset done");
  endtask : t_rerun

  initial begin
    {cyc_i, stb_i, we_i, filt_eval_i, adr_i, sel_i, dat_i, filt_hit_i} = '0;
    mismatches = 0;
    tests_run = 0;
    rst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_counts();
    t_flags();
    t_filter();
    t_rerun();
    report_and_stop();
  end

  // Run needs a few hundred cycles
  initial begin
    #400000;
    mismatches++;
    report_and_stop();
  end
endmodule : testbench
